// >>> tvc_pkg.sv
// Constants and types shared by the tap-changer voltage window controller
package tvc_pkg;
   // Register byte offsets
   localparam logic [7:0] ADDR_CTRL      = 8'h00;
   localparam logic [7:0] ADDR_PULSE_MAX = 8'h04;
   localparam logic [7:0] ADDR_PULSE_GAP = 8'h08;
   localparam logic [7:0] ADDR_STATUS    = 8'h0c;
   localparam logic [7:0] ADDR_GRP_BASE  = 8'h20;
   localparam logic [7:0] ADDR_GRP_STEP  = 8'h20;
   localparam logic [7:0] OFS_TARGET     = 8'h00;
   localparam logic [7:0] OFS_WIN1       = 8'h04;
   localparam logic [7:0] OFS_WIN2       = 8'h08;
   localparam logic [7:0] OFS_TIME1      = 8'h0c;
   localparam logic [7:0] OFS_TIME2      = 8'h10;
   localparam int         NUM_GROUPS     = 2;

   // CTRL fields
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_INV_BIT  = 2;
   localparam int CTRL_GRP_BIT  = 3;
   // STATUS fields, and low-limit LSB of the window registers
   localparam int ST_POS_LSB   = 0;
   localparam int ST_HI1_BIT   = 5;
   localparam int ST_LO1_BIT   = 6;
   localparam int ST_HI2_BIT   = 7;
   localparam int ST_LO2_BIT   = 8;
   localparam int ST_RAISE_BIT = 9;
   localparam int ST_LOWER_BIT = 10;
   localparam int ST_GAP_BIT   = 11;
   localparam int WIN_LO_LSB   = 16;

   // Reset values
   localparam logic [31:0] CTRL_RST      = 32'h0000_0004;
   localparam logic [15:0] PULSE_MAX_RST = 16'h05dc;
   localparam logic [15:0] PULSE_GAP_RST = 16'h03e8;
   localparam logic [15:0] TARGET_RST    = 16'h2710;
   localparam logic [31:0] WIN1_RST      = 32'h0064_0064;
   localparam logic [31:0] WIN2_RST      = 32'h010b_010b;
   localparam logic [19:0] TIME1_RST     = 20'hea60;
   localparam logic [19:0] TIME2_RST     = 20'hea60;

   // Position decoding
   localparam logic [4:0]  BCD_UNIT_MAX  = 5'h09;
   localparam logic [4:0]  BCD_TENS      = 5'h0a;
   localparam logic [4:0]  BIN_HIGH      = 5'h10;
   localparam logic [4:0]  SCALE_POS_MIN = 5'h01;
   localparam logic [4:0]  SCALE_POS_SPAN = 5'h12;
   localparam logic [15:0] RES_FULL_OHMS = 16'h00b4;

   // Percent arithmetic, voltages in 0.01 % of nominal
   localparam logic [15:0] PCT_SCALE     = 16'h0064;
   localparam logic [17:0] HYST_PCT      = 18'h00003;
   localparam logic [17:0] PCT_DEN       = 18'h00064;

   // Time base
   localparam int TICK_US    = 1000;
   localparam int MCLK_MHZ   = 250;
   localparam int TICK_CYCLES = TICK_US * MCLK_MHZ;

   localparam logic [1:0] AXI_OKAY   = 2'b00;
   localparam logic [1:0] AXI_SLVERR = 2'b10;

   typedef enum logic [1:0] {
      POS_BCD = 2'b00, POS_BINARY = 2'b01, POS_RES = 2'b10, POS_DIVOLT = 2'b11
   } tvc_pos_mode_t;

   typedef enum logic [1:0] {
      PS_IDLE = 2'b00, PS_PULSE = 2'b01, PS_GAP = 2'b11
   } tvc_pulse_state_t;
endpackage

// >>> tvc_acc_timer.sv
// Accumulating operate timer, definite or inverse by step size
`timescale 1ns/100ps
module tvc_acc_timer (
   input  wire logic        mclk,
   input  wire logic        reset,
   input  wire logic        run,
   input  wire logic        clear,
   input  wire logic        tick,
   input  wire logic [15:0] step,
   input  wire logic [31:0] limit,
   output logic             expired
);
   logic [31:0] acc_q;
   logic [31:0] acc_d;

   always_comb begin
      acc_d = acc_q;
      if (clear || !run) begin
         acc_d = '0;
      end else if (tick && !expired) begin
         acc_d = acc_q + {16'h0000, step};
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         acc_q <= '0;
      end else begin
         acc_q <= acc_d;
      end
   end

   // Level stays up until cleared or run drops so a busy pulse stage can defer it
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         expired <= 1'b0;
      end else begin
         expired <= run && !clear && (acc_d >= limit);
      end
   end
endmodule // tvc_acc_timer

// >>> tvc_window_ctrl.sv
// Tap position decoding, two-window voltage regulation and AXI4-Lite registers
// Functional notes
// - BCD mode: low four inputs are units 0..9, fifth input adds ten.
// - BCD decoder takes five inputs and gives positions zero to nineteen.
// - Binary and BCD are separate modes; binary low nibble reaches fifteen.
// - Resistance 0..180 ohms maps linearly onto positions 1..19.
// - Digital input voltage may be the scaled source, handled alike.
// - Every window limit is an offset from the target voltage.
// - First-window timer starts once voltage leaves either limit.
// - Staying outside for the whole definite time gives one tap command.
// - Returning inside the window clears the running operate time.
// - Window pick-ups release with 3 % hysteresis.
// - Second window timing is selectable inverse or definite.
// - Inverse time is set delay divided by deviation in percent.
// - Target and window settings follow the active setting group immediately.
// - After a pulse, new pulses are blocked for the minimum gap.
// - Pulse ends on position change or at maximum control time.
`timescale 1ns/100ps
module tvc_window_ctrl #(
   parameter int          TICK_CYC   = tvc_pkg::TICK_CYCLES,
   parameter logic [15:0] DIVOLT_FULL = 16'h03e8
) (
   input  wire logic        mclk,
   input  wire logic        reset,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic [4:0]  tapCodeIn,
   input  wire logic [15:0] tapResOhms,
   input  wire logic [15:0] tapDiVolt,
   input  wire logic [15:0] voltMeas,
   output logic             raiseCmd_q,
   output logic             lowerCmd_q,
   output logic [4:0]       tapPos_q
);
   import tvc_pkg::*;

   logic [31:0]      ctrl_q;
   logic [15:0]      pulseMax_q;
   logic [15:0]      pulseGap_q;
   logic [15:0]      target_q [NUM_GROUPS];
   logic [31:0]      win1_q   [NUM_GROUPS];
   logic [31:0]      win2_q   [NUM_GROUPS];
   logic [19:0]      time1_q  [NUM_GROUPS];
   logic [19:0]      time2_q  [NUM_GROUPS];
   logic [7:0]       awAddr_q;
   logic [31:0]      wData_q;
   logic [3:0]       wStrb_q;
   logic [4:0]       tapS1_q, tapS2_q, tapS3_q, tapStable_q;
   logic [4:0]       posPrev_q;
   logic             hi1_q, lo1_q, hi2_q, lo2_q;
   logic [17:0]      tickCnt_q;
   logic             tick_q;
   logic [15:0]      pulseCnt_q;
   tvc_pulse_state_t pState_q;

   logic             grp;
   logic [15:0]      tgt, up1, dn1, up2, dn2;
   logic signed [17:0] dev;
   logic [15:0]      absDev;
   logic             exp1, exp2, fire;
   logic [4:0]       posD;
   logic [31:0]      rdData;
   logic             rdOk, wrOk, wrDo;
   logic [7:0]       grpOfs;
   logic             grpIdx;
   logic [31:0]      wmask;

   // active group picks target, window and time settings live
   assign grp = ctrl_q[CTRL_GRP_BIT];
   // window limits are offsets around the target
   assign tgt = target_q[grp];
   assign up1 = win1_q[grp][15:0];
   assign dn1 = win1_q[grp][31:16];
   assign up2 = win2_q[grp][15:0];
   assign dn2 = win2_q[grp][31:16];
   assign dev = $signed({2'b00, voltMeas}) - $signed({2'b00, tgt});
   assign absDev = dev[17] ? 16'(-dev) : dev[15:0];

   function automatic logic [15:0] relLvl(input logic [15:0] off);
      logic [17:0] h;
      h = ({2'b00, off} * HYST_PCT) / PCT_DEN;
      relLvl = off - h[15:0];
   endfunction

   function automatic logic [4:0] scalePos(input logic [15:0] raw, input logic [15:0] full);
      logic [31:0] p;
      logic [15:0] r;
      r = (raw > full) ? full : raw;
      p = ({16'h0000, r} * {27'd0, SCALE_POS_SPAN} + {17'd0, full[15:1]}) / {16'h0000, full};
      scalePos = SCALE_POS_MIN + p[4:0];
   endfunction

   // Tap code pins: three stages, accept when stages two and three agree
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         tapS1_q <= '0;
         tapS2_q <= '0;
         tapS3_q <= '0;
         tapStable_q <= '0;
      end else begin
         tapS1_q <= tapCodeIn;
         tapS2_q <= tapS1_q;
         tapS3_q <= tapS2_q;
         if (tapS2_q == tapS3_q) begin
            tapStable_q <= tapS3_q;
         end
      end
   end

   always_comb begin
      posD = '0;
      case (tvc_pos_mode_t'(ctrl_q[CTRL_MODE_LSB +: 2]))
         // decimal units clamp at nine, fifth input worth ten
         POS_BCD: begin
            posD = ({1'b0, tapStable_q[3:0]} > BCD_UNIT_MAX) ? BCD_UNIT_MAX
                   : {1'b0, tapStable_q[3:0]};
            if (tapStable_q[4]) begin
               posD = posD + BCD_TENS;
            end
         end
         POS_BINARY: posD = {1'b0, tapStable_q[3:0]} + (tapStable_q[4] ? BIN_HIGH : 5'h00);
         POS_RES:    posD = scalePos(tapResOhms, RES_FULL_OHMS);
         // input voltage scaled the same way
         POS_DIVOLT: posD = scalePos(tapDiVolt, DIVOLT_FULL);
         default:    posD = '0;
      endcase
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         tapPos_q <= '0;
         posPrev_q <= '0;
      end else begin
         tapPos_q <= posD;
         posPrev_q <= tapPos_q;
      end
   end

   // Time base tick
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         tickCnt_q <= '0;
         tick_q <= 1'b0;
      end else begin
         tick_q <= (tickCnt_q == 18'(TICK_CYC - 1));
         tickCnt_q <= (tickCnt_q == 18'(TICK_CYC - 1)) ? '0 : tickCnt_q + 18'h00001;
      end
   end

   // pick-up flags with 3 % release hysteresis
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         hi1_q <= 1'b0;
         lo1_q <= 1'b0;
         hi2_q <= 1'b0;
         lo2_q <= 1'b0;
      end else begin
         hi1_q <= hi1_q ? (dev >= $signed({2'b00, relLvl(up1)})) : (dev > $signed({2'b00, up1}));
         lo1_q <= lo1_q ? (dev <= -$signed({2'b00, relLvl(dn1)}))
                        : (dev < -$signed({2'b00, dn1}));
         hi2_q <= hi2_q ? (dev >= $signed({2'b00, relLvl(up2)})) : (dev > $signed({2'b00, up2}));
         lo2_q <= lo2_q ? (dev <= -$signed({2'b00, relLvl(dn2)}))
                        : (dev < -$signed({2'b00, dn2}));
      end
   end

   // either expiry fires once idle, restarting both timers
   assign fire = (exp1 || exp2) && (pState_q == PS_IDLE);

   // first window definite time, cleared once back inside
   tvc_acc_timer u_timer1 (
      .mclk    (mclk),
      .reset   (reset),
      .run     (hi1_q || lo1_q),
      .clear   (fire),
      .tick    (tick_q),
      .step    (PCT_SCALE),
      .limit   ({12'h000, time1_q[grp]} * {16'h0000, PCT_SCALE}),
      .expired (exp1)
   );

   // inverse steps by deviation, reaching delay/dev%
   tvc_acc_timer u_timer2 (
      .mclk    (mclk),
      .reset   (reset),
      .run     (hi2_q || lo2_q),
      .clear   (fire),
      .tick    (tick_q),
      .step    (ctrl_q[CTRL_INV_BIT] ? absDev : PCT_SCALE),
      .limit   ({12'h000, time2_q[grp]} * {16'h0000, PCT_SCALE}),
      .expired (exp2)
   );

   // Control pulse sequencer
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         pState_q <= PS_IDLE;
         pulseCnt_q <= '0;
         raiseCmd_q <= 1'b0;
         lowerCmd_q <= 1'b0;
      end else begin
         case (pState_q)
            PS_IDLE: begin
               pulseCnt_q <= '0;
               if (fire) begin
                  pState_q <= PS_PULSE;
                  // direction from the side that picked up
                  lowerCmd_q <= hi1_q || hi2_q;
                  raiseCmd_q <= !(hi1_q || hi2_q);
               end
            end
            PS_PULSE: begin
               if (tick_q) begin
                  pulseCnt_q <= pulseCnt_q + 16'h0001;
               end
               // end on position change or maximum time
               if ((tapPos_q != posPrev_q) || (tick_q && pulseCnt_q + 16'h0001 >= pulseMax_q)) begin
                  pState_q <= PS_GAP;
                  pulseCnt_q <= '0;
                  raiseCmd_q <= 1'b0;
                  lowerCmd_q <= 1'b0;
               end
            end
            PS_GAP: begin
               // hold off new pulses for the minimum gap
               if (tick_q) begin
                  pulseCnt_q <= pulseCnt_q + 16'h0001;
               end
               if (pulseCnt_q >= pulseGap_q) begin
                  pState_q <= PS_IDLE;
               end
            end
            default: begin
               pState_q <= PS_IDLE;
               raiseCmd_q <= 1'b0;
               lowerCmd_q <= 1'b0;
            end
         endcase
      end
   end

   // Register address decode
   assign grpOfs = (awAddr_q - ADDR_GRP_BASE) & (ADDR_GRP_STEP - 8'h01);
   assign grpIdx = awAddr_q >= (ADDR_GRP_BASE + ADDR_GRP_STEP);
   assign wrDo = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
   assign wrOk = (awAddr_q == ADDR_CTRL) || (awAddr_q == ADDR_PULSE_MAX)
              || (awAddr_q == ADDR_PULSE_GAP)
              || ((awAddr_q >= ADDR_GRP_BASE) && (awAddr_q < ADDR_GRP_BASE + 8'h40)
                  && (grpOfs <= OFS_TIME2) && (awAddr_q[1:0] == 2'b00));
   assign wmask = {{8{wStrb_q[3]}}, {8{wStrb_q[2]}}, {8{wStrb_q[1]}}, {8{wStrb_q[0]}}};

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         ctrl_q <= CTRL_RST;
         pulseMax_q <= PULSE_MAX_RST;
         pulseGap_q <= PULSE_GAP_RST;
         for (int g = 0; g < NUM_GROUPS; g++) begin
            target_q[g] <= TARGET_RST;
            win1_q[g] <= WIN1_RST;
            win2_q[g] <= WIN2_RST;
            time1_q[g] <= TIME1_RST;
            time2_q[g] <= TIME2_RST;
         end
      end else if (wrDo && wrOk) begin
         if (awAddr_q == ADDR_CTRL) begin
            ctrl_q <= ((ctrl_q & ~wmask) | (wData_q & wmask)) & 32'h0000_000f;
         end else if (awAddr_q == ADDR_PULSE_MAX) begin
            pulseMax_q <= (pulseMax_q & ~wmask[15:0]) | (wData_q[15:0] & wmask[15:0]);
         end else if (awAddr_q == ADDR_PULSE_GAP) begin
            pulseGap_q <= (pulseGap_q & ~wmask[15:0]) | (wData_q[15:0] & wmask[15:0]);
         end else begin
            case (grpOfs)
               OFS_TARGET: target_q[grpIdx] <= (target_q[grpIdx] & ~wmask[15:0])
                                               | (wData_q[15:0] & wmask[15:0]);
               OFS_WIN1:   win1_q[grpIdx] <= (win1_q[grpIdx] & ~wmask) | (wData_q & wmask);
               OFS_WIN2:   win2_q[grpIdx] <= (win2_q[grpIdx] & ~wmask) | (wData_q & wmask);
               OFS_TIME1:  time1_q[grpIdx] <= (time1_q[grpIdx] & ~wmask[19:0])
                                              | (wData_q[19:0] & wmask[19:0]);
               OFS_TIME2:  time2_q[grpIdx] <= (time2_q[grpIdx] & ~wmask[19:0])
                                              | (wData_q[19:0] & wmask[19:0]);
               default: ;
            endcase
         end
      end
   end

   // Write channels accepted in either order, response after both
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= AXI_OKAY;
         awAddr_q <= '0;
         wData_q <= '0;
         wStrb_q <= '0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            awAddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            wData_q <= s_axi_wdata;
            wStrb_q <= s_axi_wstrb;
         end
         if (wrDo) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wrOk ? AXI_OKAY : AXI_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // Read mux
   always_comb begin
      logic [7:0] ro;
      logic       ri;
      ro = (s_axi_araddr - ADDR_GRP_BASE) & (ADDR_GRP_STEP - 8'h01);
      ri = s_axi_araddr >= (ADDR_GRP_BASE + ADDR_GRP_STEP);
      rdData = '0;
      rdOk = 1'b1;
      if (s_axi_araddr == ADDR_CTRL) begin
         rdData = ctrl_q;
      end else if (s_axi_araddr == ADDR_PULSE_MAX) begin
         rdData = {16'h0000, pulseMax_q};
      end else if (s_axi_araddr == ADDR_PULSE_GAP) begin
         rdData = {16'h0000, pulseGap_q};
      end else if (s_axi_araddr == ADDR_STATUS) begin
         rdData[ST_POS_LSB +: 5] = tapPos_q;
         rdData[ST_HI1_BIT] = hi1_q;
         rdData[ST_LO1_BIT] = lo1_q;
         rdData[ST_HI2_BIT] = hi2_q;
         rdData[ST_LO2_BIT] = lo2_q;
         rdData[ST_RAISE_BIT] = raiseCmd_q;
         rdData[ST_LOWER_BIT] = lowerCmd_q;
         rdData[ST_GAP_BIT] = (pState_q == PS_GAP);
      end else if ((s_axi_araddr >= ADDR_GRP_BASE) && (s_axi_araddr < ADDR_GRP_BASE + 8'h40)
                   && (s_axi_araddr[1:0] == 2'b00)) begin
         case (ro)
            OFS_TARGET: rdData = {16'h0000, target_q[ri]};
            OFS_WIN1:   rdData = win1_q[ri];
            OFS_WIN2:   rdData = win2_q[ri];
            OFS_TIME1:  rdData = {12'h000, time1_q[ri]};
            OFS_TIME2:  rdData = {12'h000, time2_q[ri]};
            default:    rdOk = 1'b0;
         endcase
      end else begin
         rdOk = 1'b0;
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= AXI_OKAY;
      end else begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdData;
            s_axi_rresp <= rdOk ? AXI_OKAY : AXI_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end
endmodule // tvc_window_ctrl

// >>> tvc_window_ctrl_properties.sv
// Bus handshake and tap command checks for the window controller
`timescale 1ns/100ps
module tvc_window_ctrl_chk
   import tvc_pkg::*;
(
   input wire logic        mclk,
   input wire logic        reset,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        raiseCmd_q,
   input wire logic        lowerCmd_q,
   input wire logic [4:0]  tapPos_q
);
   wire logic cmd = raiseCmd_q | lowerCmd_q;
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   sequence s_quiet8; !cmd [*8]; endsequence
   sequence s_posMove; cmd && $changed(tapPos_q); endsequence
   property p_oneDir; !(raiseCmd_q && lowerCmd_q); endproperty
   a_oneDir: assert property (p_oneDir) else $error("raise and lower together");
   property p_gap; $fell(cmd) |=> s_quiet8; endproperty
   a_gap: assert property (p_gap) else $error("pulse inside gap");
   property p_posEnd; s_posMove |-> ##[1:2] !cmd; endproperty
   a_posEnd: assert property (p_posEnd) else $error("pulse kept after move");
   property p_bHold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
   a_bHold: assert property (p_bHold) else $error("bvalid dropped");
   property p_rHold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid; endproperty
   a_rHold: assert property (p_rHold) else $error("rvalid dropped");
   property p_rAns; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
   a_rAns: assert property (p_rAns) else $error("read answer late");
   property p_bAns;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
   endproperty
   a_bAns: assert property (p_bAns) else $error("write answer late");
   property p_busy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
   a_busy: assert property (p_busy) else $error("ready during response");
   property p_errZero; s_axi_rvalid && s_axi_rresp == AXI_SLVERR |-> s_axi_rdata == 32'h0;
   endproperty
   a_errZero: assert property (p_errZero) else $error("error read not zero");
endmodule // tvc_window_ctrl_chk

bind tvc_window_ctrl tvc_window_ctrl_chk u_chk (.mclk(mclk), .reset(reset),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .raiseCmd_q(raiseCmd_q), .lowerCmd_q(lowerCmd_q),
   .tapPos_q(tapPos_q));

// >>> tvc_tap_model.sv
// Behavioural on-load tap changer with BCD position contacts
`timescale 1ns/100ps
module tvc_tap_model #(
   parameter int STEP   = 167,
   parameter int OP_DLY = 20
) (
   input  wire logic        mclk,
   input  wire logic        raiseCmd,
   input  wire logic        lowerCmd,
   input  wire logic        stall,
   input  wire logic [15:0] baseVolt,
   output logic [4:0]       tapCode,
   output logic [15:0]      voltMeas
);
   int   pos = 9;
   int   cnt = 0;
   logic moved = 1'b0;
   // One step per pulse after the drive time
   always @(posedge mclk) begin
      if (!(raiseCmd || lowerCmd)) begin
         cnt <= 0;
         moved <= 1'b0;
      end else if (!moved && !stall) begin
         cnt <= cnt + 1;
         if (cnt == OP_DLY) begin
            pos <= raiseCmd ? pos + 1 : pos - 1;
            moved <= 1'b1;
         end
      end
   end
   always_comb begin
      tapCode = (pos >= 10) ? {1'b1, 4'(pos - 10)} : 5'(pos);
      voltMeas = 16'(int'(baseVolt) + (pos - 9) * STEP);
   end
endmodule // tvc_tap_model

// >>> tb.sv
// Register and regulation testbench for the window controller
`timescale 1ns/100ps
module tb;
   import tvc_pkg::*;
   logic        mclk, reset, awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid, raise, lower, useTb, stall;
   logic        cmdSeen;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, d;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, r;
   logic [4:0]  tbCode, modelCode, tapPos;
   logic [15:0] ana, baseVolt, voltMeas;
   int          n_mismatch, num_checks, i, n;
   logic [4:0]  codes [6] = '{5'h09, 5'h0f, 5'h18, 5'h13, 5'h0f, 5'h1f};
   logic [15:0] anas [6] = '{16'h0, 16'h5a, 16'hb4, 16'h12c, 16'h1f4, 16'h3e8};
   logic [4:0]  exps [12] = '{5'h09, 5'h09, 5'h12, 5'h0d, 5'h0f, 5'h1f,
                              5'h01, 5'h0a, 5'h13, 5'h13, 5'h0a, 5'h13};
   logic [15:0] hv [3] = '{16'h27a6, 16'h2772, 16'h2770};
   tvc_window_ctrl #(.TICK_CYC(10)) u_tvc_window_ctrl (.mclk(mclk), .reset(reset),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .tapCodeIn(useTb ? tbCode : modelCode), .tapResOhms(ana), .tapDiVolt(ana),
      .voltMeas(voltMeas), .raiseCmd_q(raise), .lowerCmd_q(lower), .tapPos_q(tapPos));
   // step 167 against default windows 100 and 267
   tvc_tap_model u_tvc_tap_model (.mclk(mclk), .raiseCmd(raise), .lowerCmd(lower),
      .stall(stall), .baseVolt(baseVolt), .tapCode(modelCode), .voltMeas(voltMeas));
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   always @(posedge mclk) cmdSeen <= !reset && (cmdSeen || raise || lower);
   task chk(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task wrap_up;
      $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task tmo;
      n_mismatch++;
      wrap_up();
   endtask
   task wr(input logic [7:0] a, input logic [31:0] v);
      int k;
      awaddr <= a;
      wdata <= v;
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (k = 0; k < 50; k++) begin
         @(posedge mclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      if (k == 50) tmo();
      chk({30'h0, bresp}, {30'h0, AXI_OKAY});
      bready <= 1'b0;
      @(posedge mclk);
   endtask
   task rd(input logic [7:0] a);
      int k;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (k = 0; k < 50; k++) begin
         @(posedge mclk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      if (k == 50) tmo();
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      @(posedge mclk);
   endtask
   task waitCmd(input logic lvl);
      n = 0;
      while ((raise || lower) !== lvl) begin
         @(posedge mclk);
         n++;
         if (n > 3000) tmo();
      end
   endtask
   initial begin
      {reset, awvalid, wvalid, bready, arvalid, rready, useTb, stall} = 8'h82;
      {awaddr, araddr, wdata, wstrb, tbCode, ana} = '0;
      baseVolt = 16'h2710;
      repeat (10) @(posedge mclk);
      reset <= 1'b0;
      @(posedge mclk);
      rd(ADDR_CTRL); chk(d, CTRL_RST);
      rd(ADDR_PULSE_MAX); chk(d, {16'h0, PULSE_MAX_RST});
      rd(ADDR_GRP_BASE + OFS_WIN2); chk(d, WIN2_RST);
      rd(8'h80); chk({d[29:0], r}, {30'h0, AXI_SLVERR});
      wr(ADDR_PULSE_MAX, 32'h5);
      wr(ADDR_PULSE_GAP, 32'h2);
      wr(ADDR_GRP_BASE + OFS_TIME2, 32'h3e8);
      for (i = 0; i < 12; i++) begin
         wr(ADDR_CTRL, {29'h1, 2'(i < 4 ? 0 : i < 6 ? 1 : i < 10 ? 2 : 3)});
         if (i < 6) tbCode <= codes[i];
         else ana <= anas[i < 10 ? i - 6 : i - 6];
         repeat (8) @(posedge mclk);
         chk({27'h0, tapPos}, {27'h0, exps[i]});
      end
      useTb <= 1'b0;
      wr(ADDR_CTRL, 32'h4);
      for (i = 0; i < 3; i++) begin
         baseVolt <= hv[i];
         repeat (8) @(posedge mclk);
         rd(ADDR_STATUS); chk({31'h0, d[ST_HI1_BIT]}, {31'h0, i < 2});
      end
      wr(ADDR_GRP_BASE + OFS_TIME1, 32'h14);
      repeat (2) begin
         baseVolt <= 16'h27a6;
         repeat (150) @(posedge mclk);
         baseVolt <= 16'h2710;
         repeat (20) @(posedge mclk);
      end
      repeat (300) @(posedge mclk);
      chk({31'h0, cmdSeen}, 32'h0);
      wr(ADDR_GRP_BASE + OFS_TIME1, 32'h3);
      baseVolt <= 16'h27a6;
      waitCmd(1'b1);
      chk({30'h0, lower, raise}, 32'h2);
      chk(32'(n >= 18 && n <= 40), 32'h1);
      waitCmd(1'b0);
      chk({27'h0, tapPos}, 32'h8);
      stall <= 1'b1;
      baseVolt <= 16'h2721;
      waitCmd(1'b1);
      chk({30'h0, lower, raise}, 32'h1);
      waitCmd(1'b0);
      chk(32'(n >= 40 && n <= 60), 32'h1);
      stall <= 1'b0;
      waitCmd(1'b1);
      waitCmd(1'b0);
      chk({27'h0, tapPos}, 32'h9);
      wr(ADDR_GRP_BASE + OFS_TIME1, 32'h3e8);
      wr(ADDR_GRP_BASE + OFS_TIME2, 32'h28);
      repeat (30) @(posedge mclk);
      baseVolt <= 16'h28a0;
      waitCmd(1'b1);
      chk(32'(n >= 80 && n <= 130), 32'h1);
      waitCmd(1'b0);
      wr(ADDR_CTRL, 32'h0);
      repeat (30) @(posedge mclk);
      baseVolt <= 16'h2947;
      waitCmd(1'b1);
      chk(32'(n >= 380 && n <= 430), 32'h1);
      waitCmd(1'b0);
      baseVolt <= 16'h28f4;
      repeat (10) @(posedge mclk);
      rd(ADDR_STATUS); chk({23'h0, d[8:0]}, {23'h0, 4'h1, 5'h07});
      wr(ADDR_GRP_BASE + ADDR_GRP_STEP + OFS_TARGET, 32'h2904);
      wr(ADDR_CTRL, 32'h8);
      repeat (8) @(posedge mclk);
      rd(ADDR_STATUS); chk({23'h0, d[8:0]}, {23'h0, 4'ha, 5'h07});
      wrap_up();
   end
endmodule // tb
